// [hw/cfe_pkg.sv]
package cfe_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] CFE_ADDR_FAULT_STATE = 8'h0E;
  localparam logic [7:0] CFE_ADDR_CHG_EVENT_1 = 8'h0F;
  localparam logic [7:0] CFE_ADDR_CHG_EVENT_2 = 8'h10;
  localparam logic [7:0] CFE_ADDR_FAULT_EVENT = 8'h11;
  localparam logic [7:0] CFE_EVENT_RESET = 8'h00;
  localparam logic [7:0] CFE_READ_NONE = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CFE_FS_OVP_BIT = 7;
  localparam int CFE_FS_TSHUT_BIT = 6;
  localparam int CFE_FS_TMR_BIT = 4;
  localparam int CFE_E1_ICR_BIT = 6;
  localparam int CFE_E1_IVR_BIT = 5;
  localparam int CFE_E1_THERMAL_REGULATION_BIT = 4;
  localparam int CFE_E1_WD_BIT = 3;
  localparam int CFE_E1_CHG_BIT = 0;
  localparam int CFE_E2_PG_BIT = 7;
  localparam int CFE_E2_SRC_BIT = 4;
  localparam int CFE_E2_TEMP_BIT = 2;
  localparam int CFE_E2_OPT_BIT = 1;
  localparam int CFE_FE_OVP_BIT = 7;
  localparam int CFE_FE_TSHUT_BIT = 6;
  localparam int CFE_FE_TMR_BIT = 4;

  // ------------------------------------------------------------
  // synchronised status vector layout
  // ------------------------------------------------------------
  localparam int CFE_SYNC_W = 19;
  localparam int CFE_S_ICR = 0;
  localparam int CFE_S_IVR = 1;
  localparam int CFE_S_THERMAL_REGULATION = 2;
  localparam int CFE_S_WD = 3;
  localparam int CFE_S_CHG = 4;
  localparam int CFE_S_PG = 7;
  localparam int CFE_S_SRC = 8;
  localparam int CFE_S_TEMP = 11;
  localparam int CFE_S_OPT = 14;
  localparam int CFE_S_OVP = 16;
  localparam int CFE_S_TSHUT = 17;
  localparam int CFE_S_TMR = 18;
  localparam logic [CFE_SYNC_W-1:0] CFE_SYNC_RESET = 19'h00000;

  // optimizer state codes
  localparam logic [1:0] CFE_OPT_DISABLED = 2'h0;
  localparam logic [1:0] CFE_OPT_RUNNING = 2'h1;
  localparam logic [1:0] CFE_OPT_FOUND = 2'h2;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CFE_CLOCK_HZ = 50000000;
  localparam logic [2:0] CFE_ARM_CYCLES = 3'h5;
  localparam logic [2:0] CFE_ARM_RESET = 3'h0;

  typedef enum logic [0:0] {
    CFE_ARMING = 1'b0,
    CFE_LIVE = 1'b1
  } cfe_state_t;

endpackage : cfe_pkg

// [hw/cfe_stat_if.sv]
`timescale 1ns/1ps
interface cfe_stat_if;
  import cfe_pkg::*;
  logic [CFE_SYNC_W-1:0] raw;
  logic [CFE_SYNC_W-1:0] stable;
  modport sync (input raw, output stable);
  modport core (output raw, input stable);
endinterface : cfe_stat_if

// [hw/cfe_sync.sv]
`timescale 1ns/1ps
module cfe_sync
  import cfe_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  cfe_stat_if.sync si
);

  logic [CFE_SYNC_W-1:0] ff1_r;
  logic [CFE_SYNC_W-1:0] ff2_r;
  logic [CFE_SYNC_W-1:0] ff3_r;
  logic [CFE_SYNC_W-1:0] stable_r;
  logic [CFE_SYNC_W-1:0] stable_nxt;

  // ------------------------------------------------------------
  // per-bit acceptance
  // ------------------------------------------------------------
  // ff1 feeds only ff2; a bit moves only once ff2 and ff3 agree
  genvar g;
  generate
    for (g = 0; g < CFE_SYNC_W; g++)
    begin : g_bit
      always_comb
      begin
        stable_nxt[g] = (ff2_r[g] == ff3_r[g]) ? ff3_r[g] : stable_r[g];
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ff1_r <= CFE_SYNC_RESET;
      ff2_r <= CFE_SYNC_RESET;
      ff3_r <= CFE_SYNC_RESET;
      stable_r <= CFE_SYNC_RESET;
    end
    else
    begin
      ff1_r <= si.raw;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      stable_r <= stable_nxt;
    end
  end

  assign si.stable = stable_r;

endmodule : cfe_sync

// [hw/cfe_top.sv]
// Behaviour
// - fault state bit 7 shows overvoltage
// - fault state bit 6 shows thermal shutdown
// - fault state bit 4 shows timer expiry
// - reserved bits always read zero
// - event registers 0Fh,10h,11h reset zero
// - event1 bit 6 on current regulation rise
// - event1 bit 5 on voltage regulation rise
// - event1 bit 4 on thermal regulation rise
// - event1 bit 3 on watchdog expiry rise
// - event1 bit 0 on charge phase change
// - event2 bit 7 on power good toggle
// - event2 bit 4 on source type change
// - event2 bit 2 on temperature zone change
// - event2 bit 1 on optimizer state change
// - fault event bit 7 on overvoltage entry
// - fault event bit 6 on shutdown entry
// - fault event bit 4 on timer rise
// - optimizer codes 00,01,10 and reserved 11
// - watchdog state bit set after expiry
`timescale 1ns/1ps
module cfe_top
  import cfe_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic REG_RST,
  input wire logic RD_EN,
  input wire logic [7:0] RD_ADDR,
  output logic [7:0] RD_DATA,
  input wire logic INPUT_CURRENT_REGULATION,
  input wire logic INPUT_VOLTAGE_REGULATION,
  input wire logic THERMAL_REGULATION,
  input wire logic WATCHDOG_EXPIRED_STATE,
  input wire logic [2:0] CHARGE_PHASE,
  input wire logic POWER_GOOD_SIGNAL,
  input wire logic [2:0] INPUT_SOURCE_TYPE,
  input wire logic [2:0] BATTERY_TEMP_ZONE,
  input wire logic [1:0] INPUT_OPTIMIZER_STATE,
  input wire logic INPUT_OVERVOLTAGE_STATE,
  input wire logic THERMAL_SHUTDOWN_STATE,
  input wire logic SAFETY_TIMER_EXPIRED_STATE
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction : rose

  function automatic logic read_hit(input logic en,
                                    input logic [7:0] addr,
                                    input logic [7:0] reg_addr);
    read_hit = en && (addr == reg_addr);
  endfunction : read_hit

  // ------------------------------------------------------------
  // input synchronisation
  // ------------------------------------------------------------
  cfe_stat_if si ();

  // status sources may be analog, so every bit is synchronised
  // limitation: a pulse shorter than two clocks may be missed
  assign si.raw = {SAFETY_TIMER_EXPIRED_STATE,
                   THERMAL_SHUTDOWN_STATE,
                   INPUT_OVERVOLTAGE_STATE,
                   INPUT_OPTIMIZER_STATE,
                   BATTERY_TEMP_ZONE,
                   INPUT_SOURCE_TYPE,
                   POWER_GOOD_SIGNAL,
                   CHARGE_PHASE,
                   WATCHDOG_EXPIRED_STATE,
                   THERMAL_REGULATION,
                   INPUT_VOLTAGE_REGULATION,
                   INPUT_CURRENT_REGULATION};

  cfe_sync u_sync (
    .clock(CLOCK),
    .rst(RST),
    .si(si.sync)
  );

  // ------------------------------------------------------------
  // arming after reset
  // ------------------------------------------------------------
  // the synchroniser starts from zero; arming waits until the
  // first real values are through, so they raise no false events
  // trade-off: events in the first six clocks are lost
  cfe_state_t state_r;
  cfe_state_t state_nxt;
  logic [2:0] arm_cnt_r;
  logic [2:0] arm_cnt_nxt;

  always_comb
  begin
    state_nxt = state_r;
    arm_cnt_nxt = arm_cnt_r;
    case (state_r)
      CFE_ARMING:
      begin
        if (arm_cnt_r == CFE_ARM_CYCLES)
        begin
          state_nxt = CFE_LIVE;
        end
        else
        begin
          arm_cnt_nxt = arm_cnt_r + 3'h1;
        end
      end
      CFE_LIVE:
      begin
        state_nxt = CFE_LIVE;
      end
      default:
      begin
        state_nxt = CFE_ARMING;
        arm_cnt_nxt = CFE_ARM_RESET;
      end
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      state_r <= CFE_ARMING;
      arm_cnt_r <= CFE_ARM_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      arm_cnt_r <= arm_cnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // event detection
  // ------------------------------------------------------------
  logic [CFE_SYNC_W-1:0] prev_r;
  logic [CFE_SYNC_W-1:0] cur;
  logic live;
  logic [7:0] set_e1;
  logic [7:0] set_e2;
  logic [7:0] set_fe;

  // prev_r tracks cur while arming, so detection starts from the
  // status seen at the moment it goes live
  assign cur = si.stable;
  assign live = (state_r == CFE_LIVE);

  always_comb
  begin
    set_e1 = CFE_EVENT_RESET;
    set_e2 = CFE_EVENT_RESET;
    set_fe = CFE_EVENT_RESET;
    if (live)
    begin
      set_e1[CFE_E1_ICR_BIT] = rose(cur[CFE_S_ICR], prev_r[CFE_S_ICR]);
      set_e1[CFE_E1_IVR_BIT] = rose(cur[CFE_S_IVR], prev_r[CFE_S_IVR]);
      set_e1[CFE_E1_THERMAL_REGULATION_BIT] =
        rose(cur[CFE_S_THERMAL_REGULATION], prev_r[CFE_S_THERMAL_REGULATION]);
      set_e1[CFE_E1_WD_BIT] = rose(cur[CFE_S_WD], prev_r[CFE_S_WD]);
      set_e1[CFE_E1_CHG_BIT] =
        (cur[CFE_S_CHG+:3] != prev_r[CFE_S_CHG+:3]);
      set_e2[CFE_E2_PG_BIT] = cur[CFE_S_PG] ^ prev_r[CFE_S_PG];
      set_e2[CFE_E2_SRC_BIT] =
        (cur[CFE_S_SRC+:3] != prev_r[CFE_S_SRC+:3]);
      set_e2[CFE_E2_TEMP_BIT] =
        (cur[CFE_S_TEMP+:3] != prev_r[CFE_S_TEMP+:3]);
      // any move among the four codes counts
      set_e2[CFE_E2_OPT_BIT] =
        (cur[CFE_S_OPT+:2] != prev_r[CFE_S_OPT+:2]);
      set_fe[CFE_FE_OVP_BIT] = rose(cur[CFE_S_OVP], prev_r[CFE_S_OVP]);
      set_fe[CFE_FE_TSHUT_BIT] =
        rose(cur[CFE_S_TSHUT], prev_r[CFE_S_TSHUT]);
      set_fe[CFE_FE_TMR_BIT] = rose(cur[CFE_S_TMR], prev_r[CFE_S_TMR]);
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      prev_r <= CFE_SYNC_RESET;
    end
    else
    begin
      prev_r <= cur;
    end
  end

  // ------------------------------------------------------------
  // event flags
  // ------------------------------------------------------------
  logic [7:0] ev1_r;
  logic [7:0] ev2_r;
  logic [7:0] fev_r;
  logic [7:0] ev1_nxt;
  logic [7:0] ev2_nxt;
  logic [7:0] fev_nxt;
  logic clr1;
  logic clr2;
  logic clr3;

  // register reset clears on every clock it is held
  // a read clears only its own register
  assign clr1 = REG_RST | read_hit(RD_EN, RD_ADDR, CFE_ADDR_CHG_EVENT_1);
  assign clr2 = REG_RST | read_hit(RD_EN, RD_ADDR, CFE_ADDR_CHG_EVENT_2);
  assign clr3 = REG_RST | read_hit(RD_EN, RD_ADDR, CFE_ADDR_FAULT_EVENT);

  // a new event in the clearing cycle wins over the clear
  always_comb
  begin
    // register reset clears; no watchdog term
    ev1_nxt = (clr1 ? CFE_EVENT_RESET : ev1_r) | set_e1;
    ev2_nxt = (clr2 ? CFE_EVENT_RESET : ev2_r) | set_e2;
    fev_nxt = (clr3 ? CFE_EVENT_RESET : fev_r) | set_fe;
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      ev1_r <= CFE_EVENT_RESET;
      ev2_r <= CFE_EVENT_RESET;
      fev_r <= CFE_EVENT_RESET;
    end
    else
    begin
      ev1_r <= ev1_nxt;
      ev2_r <= ev2_nxt;
      fev_r <= fev_nxt;
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  logic [7:0] fault_state;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;

  // ------------------------------------------------------------
  // fault state view
  // ------------------------------------------------------------
  // live status, not latched: it reads as the faults stand now
  always_comb
  begin
    fault_state = CFE_READ_NONE;
    fault_state[CFE_FS_OVP_BIT] = cur[CFE_S_OVP];
    fault_state[CFE_FS_TSHUT_BIT] = cur[CFE_S_TSHUT];
    fault_state[CFE_FS_TMR_BIT] = cur[CFE_S_TMR];
  end

  always_comb
  begin
    rd_data_nxt = rd_data_r;
    if (RD_EN)
    begin
      case (RD_ADDR)
        CFE_ADDR_FAULT_STATE: rd_data_nxt = fault_state;
        CFE_ADDR_CHG_EVENT_1: rd_data_nxt = ev1_r;
        CFE_ADDR_CHG_EVENT_2: rd_data_nxt = ev2_r;
        CFE_ADDR_FAULT_EVENT: rd_data_nxt = fev_r;
        // unmapped addresses read zero and clear nothing
        default: rd_data_nxt = CFE_READ_NONE;
      endcase
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      rd_data_r <= CFE_READ_NONE;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // answer one clock after the strobe, held until the next strobe
  assign RD_DATA = rd_data_r;

endmodule : cfe_top

// [test/cfe_top_sva.sv]
`timescale 1ns/1ps
module cfe_top_sva
  import cfe_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic REG_RST,
  input wire logic RD_EN,
  input wire logic [7:0] RD_ADDR,
  input wire logic [7:0] RD_DATA,
  input wire logic INPUT_CURRENT_REGULATION,
  input wire logic INPUT_VOLTAGE_REGULATION,
  input wire logic THERMAL_REGULATION,
  input wire logic WATCHDOG_EXPIRED_STATE,
  input wire logic [2:0] CHARGE_PHASE,
  input wire logic POWER_GOOD_SIGNAL,
  input wire logic [2:0] INPUT_SOURCE_TYPE,
  input wire logic [2:0] BATTERY_TEMP_ZONE,
  input wire logic [1:0] INPUT_OPTIMIZER_STATE,
  input wire logic INPUT_OVERVOLTAGE_STATE,
  input wire logic THERMAL_SHUTDOWN_STATE,
  input wire logic SAFETY_TIMER_EXPIRED_STATE
);
  logic [18:0] st;
  logic [2:0] fs;
  logic ev_rd;
  assign st = {SAFETY_TIMER_EXPIRED_STATE, THERMAL_SHUTDOWN_STATE,
    INPUT_OVERVOLTAGE_STATE, INPUT_OPTIMIZER_STATE, BATTERY_TEMP_ZONE,
    INPUT_SOURCE_TYPE, POWER_GOOD_SIGNAL, CHARGE_PHASE,
    WATCHDOG_EXPIRED_STATE, THERMAL_REGULATION, INPUT_VOLTAGE_REGULATION,
    INPUT_CURRENT_REGULATION};
  assign fs = {INPUT_OVERVOLTAGE_STATE, THERMAL_SHUTDOWN_STATE,
    SAFETY_TIMER_EXPIRED_STATE};
  assign ev_rd = RD_EN && RD_ADDR >= CFE_ADDR_CHG_EVENT_1 &&
    RD_ADDR <= CFE_ADDR_FAULT_EVENT;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  rd_hold_a: assert property (
    !RD_EN |=> $stable(RD_DATA)) else $error("read data moved");
  unmapped_zero_a: assert property (
    RD_EN && !(RD_ADDR inside {[CFE_ADDR_FAULT_STATE:CFE_ADDR_FAULT_EVENT]})
    |=> RD_DATA == 8'h00) else $error("unmapped read not zero");
  fs_rsvd_a: assert property (
    RD_EN && RD_ADDR == CFE_ADDR_FAULT_STATE |=> (RD_DATA & 8'h2F) == 8'h00)
    else $error("fault state reserved bit set");
  e1_rsvd_a: assert property (
    RD_EN && RD_ADDR == CFE_ADDR_CHG_EVENT_1 |=> (RD_DATA & 8'h86) == 8'h00)
    else $error("event1 reserved bit set");
  e2_rsvd_a: assert property (
    RD_EN && RD_ADDR == CFE_ADDR_CHG_EVENT_2 |=> (RD_DATA & 8'h69) == 8'h00)
    else $error("event2 reserved bit set");
  fe_rsvd_a: assert property (
    RD_EN && RD_ADDR == CFE_ADDR_FAULT_EVENT |=> (RD_DATA & 8'h2F) == 8'h00)
    else $error("fault event reserved bit set");
  fault_state_a: assert property (
    $stable(fs) [*6] ##0 RD_EN && RD_ADDR == CFE_ADDR_FAULT_STATE
    |=> {RD_DATA[7], RD_DATA[6], RD_DATA[4]} == $past(fs))
    else $error("fault state does not follow inputs");
  read_clears_a: assert property (
    $stable(st) [*8] ##0 ev_rd && $past(RD_EN) && RD_ADDR == $past(RD_ADDR)
    |=> RD_DATA == 8'h00) else $error("flag survived its read");
  reg_rst_clears_a: assert property (
    $stable(st) [*8] ##0 REG_RST ##1 ev_rd |=> RD_DATA == 8'h00)
    else $error("flag survived register reset");
endmodule : cfe_top_sva

bind cfe_top cfe_top_sva i_sva (.*);

// [test/cfe_host.sv]
`timescale 1ns/1ps
module cfe_host
  import cfe_pkg::*;
(
  input wire logic CLOCK,
  output logic RD_EN,
  output logic [7:0] RD_ADDR,
  input wire logic [7:0] RD_DATA
);
  initial
  begin
    RD_EN = 1'b0;
    RD_ADDR = 8'h00;
  end

  // called just after an edge; hold keeps the strobe up for back to back
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
    input logic hold);
    if (!RD_EN)
      RD_EN = 1'b1;
    RD_ADDR = a;
    @(posedge CLOCK);
    #1;
    d = RD_DATA;
    if (!hold)
    begin
      RD_EN = 1'b0;
      // released address shows a changed pattern, not the last value
      RD_ADDR = ~a;
    end
  endtask : rd
endmodule : cfe_host

// [test/cfe_top_tb.sv]
`timescale 1ns/1ps
module cfe_top_tb;
  import cfe_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_rst = 1'b0;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [CFE_SYNC_W-1:0] st = CFE_SYNC_RESET;
  logic [CFE_SYNC_W-1:0] old;
  logic [CFE_SYNC_W-1:0] n;
  logic [7:0] got;
  integer seed = 32'h6cf5;
  integer failures = 0;
  integer tests_run = 0;
  integer cyc = 0;

  always #10 clock = ~clock;

  cfe_top i_dut (
    .CLOCK(clock), .RST(rst), .REG_RST(reg_rst), .RD_EN(rd_en),
    .RD_ADDR(rd_addr), .RD_DATA(rd_data),
    .INPUT_CURRENT_REGULATION(st[CFE_S_ICR]),
    .INPUT_VOLTAGE_REGULATION(st[CFE_S_IVR]),
    .THERMAL_REGULATION(st[CFE_S_THERMAL_REGULATION]),
    .WATCHDOG_EXPIRED_STATE(st[CFE_S_WD]),
    .CHARGE_PHASE(st[CFE_S_CHG+:3]),
    .POWER_GOOD_SIGNAL(st[CFE_S_PG]),
    .INPUT_SOURCE_TYPE(st[CFE_S_SRC+:3]),
    .BATTERY_TEMP_ZONE(st[CFE_S_TEMP+:3]),
    .INPUT_OPTIMIZER_STATE(st[CFE_S_OPT+:2]),
    .INPUT_OVERVOLTAGE_STATE(st[CFE_S_OVP]),
    .THERMAL_SHUTDOWN_STATE(st[CFE_S_TSHUT]),
    .SAFETY_TIMER_EXPIRED_STATE(st[CFE_S_TMR])
  );

  cfe_host i_host (.CLOCK(clock), .RD_EN(rd_en), .RD_ADDR(rd_addr),
    .RD_DATA(rd_data));

  // ------------------------------------------------------------
  // expectation and checking
  // ------------------------------------------------------------
  function automatic logic [23:0] exp_ev(logic [18:0] o, logic [18:0] v);
    logic [18:0] r;
    logic [18:0] c;
    r = v & ~o;
    c = v ^ o;
    exp_ev = {1'h0, r[CFE_S_ICR], r[CFE_S_IVR], r[CFE_S_THERMAL_REGULATION], r[CFE_S_WD],
      2'h0, |c[CFE_S_CHG+:3], c[CFE_S_PG], 2'h0, |c[CFE_S_SRC+:3], 1'h0,
      |c[CFE_S_TEMP+:3], |c[CFE_S_OPT+:2], 1'h0, r[CFE_S_OVP],
      r[CFE_S_TSHUT], 1'h0, r[CFE_S_TMR], 4'h0};
  endfunction : exp_ev

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("[ERR] %0t read %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // event1 and fault event regs read twice back to back, event2 once: second read must be empty
  task automatic sweep(input logic [23:0] e);
    logic [7:0] fsx;
    fsx = {st[CFE_S_OVP], st[CFE_S_TSHUT], 1'h0, st[CFE_S_TMR], 4'h0};
    i_host.rd(CFE_ADDR_CHG_EVENT_1, got, 1'b1);
    chk(got, e[23:16]);
    i_host.rd(CFE_ADDR_CHG_EVENT_1, got, 1'b1);
    chk(got, CFE_EVENT_RESET);
    i_host.rd(CFE_ADDR_CHG_EVENT_2, got, 1'b1);
    chk(got, e[15:8]);
    i_host.rd(CFE_ADDR_FAULT_EVENT, got, 1'b1);
    chk(got, e[7:0]);
    i_host.rd(CFE_ADDR_FAULT_EVENT, got, 1'b1);
    chk(got, CFE_EVENT_RESET);
    i_host.rd(CFE_ADDR_FAULT_STATE, got, 1'b0);
    chk(got, fsx);
    @(posedge clock);
    #1;
  endtask : sweep

  task automatic step(input logic [18:0] v);
    old = st;
    st = v;
    repeat (8) @(posedge clock);
    #1;
    sweep(exp_ev(old, st));
  endtask : step

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      failures = failures + 1;
      print_verdict;
    end
  end

  initial
  begin
    st = 19'($random(seed));
    repeat (12) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    sweep(24'h000000);
    for (int k = 0; k < 4; k++)
    begin
      n = st;
      n[CFE_S_OPT+:2] = 2'(k);
      step(n);
    end
    for (int k = 0; k < 60; k++)
      step(19'($random(seed)));
    n = st;
    n[CFE_S_WD] = 1'b0;
    step(n);
    // watchdog expiry after a phase change must not wipe that flag
    old = st;
    st[CFE_S_CHG+:3] = ~st[CFE_S_CHG+:3];
    repeat (8) @(posedge clock);
    #1;
    st[CFE_S_WD] = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    sweep(exp_ev(old, st));
    // event landing on the read edge survives the clear
    st[CFE_S_CHG+:3] = ~st[CFE_S_CHG+:3];
    repeat (4) @(posedge clock);
    #1;
    i_host.rd(CFE_ADDR_CHG_EVENT_1, got, 1'b1);
    chk(got, CFE_EVENT_RESET);
    i_host.rd(CFE_ADDR_CHG_EVENT_1, got, 1'b0);
    chk(got, 8'h01);
    st[CFE_S_SRC+:3] = ~st[CFE_S_SRC+:3];
    st[CFE_S_PG] = ~st[CFE_S_PG];
    repeat (8) @(posedge clock);
    #1;
    reg_rst = 1'b1;
    @(posedge clock);
    #1;
    reg_rst = 1'b0;
    sweep(24'h000000);
    for (int k = 0; k < 8; k++)
    begin
      i_host.rd(8'($random(seed)) | 8'h20, got, 1'b1);
      chk(got, CFE_READ_NONE);
    end
    // a pending flag must not survive a reset
    st[CFE_S_TEMP+:3] = ~st[CFE_S_TEMP+:3];
    repeat (8) @(posedge clock);
    #1;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    sweep(24'h000000);
    print_verdict;
  end
endmodule : cfe_top_tb
